//--- hdl/fbp_pkg.sv
// Shared constants, register map and carrier types of the FIFO byte port block
package fbp_pkg;

   // Register indices; byte address on the bus is four times the index
   localparam logic [7:0] IDX_READ_BYTE_LO = 8'h8C;
   localparam logic [7:0] IDX_READ_BYTE_HI = 8'h8D;
   localparam logic [7:0] IDX_WRITE_BYTE_LO = 8'h8E;
   localparam logic [7:0] IDX_WRITE_BYTE_HI = 8'h8F;
   localparam logic [7:0] IDX_PIN_STATUS = 8'h90;
   localparam logic [7:0] IDX_DRIVE_CONTROL = 8'h91;
   localparam logic [7:0] IDX_CHAN_ONE_CONTROL = 8'h80;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h98;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h99;

   // Pin status fields
   localparam int ST_REQUEST = 7;
   localparam int ST_ACK = 6;
   localparam int ST_INTERRUPT = 5;
   localparam int ST_READY = 4;
   localparam int ST_DIAG = 1;
   localparam int ST_ACTIVE = 0;

   // Drive control fields
   localparam int CT_CLEAR = 6;
   localparam int CT_DIR = 3;
   localparam int CT_LAUNCH = 0;

   // Channel one control fields
   localparam int C1_ACCESS_MODE = 0;
   localparam int C1_DIR = 1;

   // Interrupt status / mask fields
   localparam int IRQ_DONE = 0;
   localparam int IRQ_DRIVE_INT = 1;
   localparam int IRQ_BITS = 2;

   // Values after reset
   localparam logic [7:0] RST_DRIVE_CONTROL = 8'h00;
   localparam logic [7:0] RST_CHAN_ONE_CONTROL = 8'h00;
   localparam logic [1:0] RST_IRQ = 2'h0;

   // Direction encodings
   localparam logic DIR_DRIVE_READ = 1'b0;
   localparam logic DIR_DRIVE_WRITE = 1'b1;
   localparam logic C1_DIR_READ = 1'b0;
   localparam logic C1_DIR_WRITE = 1'b1;

   // Drive transfer engine states
   typedef enum logic [1:0] {
      ENG_IDLE = 2'b01,
      ENG_RUN = 2'b10
   } fbp_eng_e;

   // Drive bus pins as seen by this block, at their pin levels
   typedef struct packed {
      logic drive_request_pin;
      logic drive_ack_pin_n;
      logic drive_interrupt_pin;
      logic drive_ready_pin;
      logic drive_diag_pin_n;
      logic drive_active_pin_n;
   } fbp_drive_pins_s;

endpackage : fbp_pkg

//--- hdl/fbp_drive_engine.sv
// Drive transfer engine: launch, run, end, abort and logic clear
`timescale 1ns/1ns
module fbp_drive_engine
(
   input wire logic clk,
   input wire logic rst,
   input wire logic logic_clear,
   input wire logic launch,
   input wire logic abort,
   input wire logic xfer_end,
   output logic active,
   output logic done
);

   fbp_pkg::fbp_eng_e state;

   ////////////////////////////////////////////////////////////////////////////
   // State; clear wins over everything since software promises it is quiet
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state <= fbp_pkg::ENG_IDLE;
      end
      else if (logic_clear)
      begin
         state <= fbp_pkg::ENG_IDLE;
      end
      else
      begin
         case (state)
            fbp_pkg::ENG_IDLE:
            begin
               if (launch)
               begin
                  state <= fbp_pkg::ENG_RUN;
               end
            end
            fbp_pkg::ENG_RUN:
            begin
               if (abort || xfer_end)
               begin
                  state <= fbp_pkg::ENG_IDLE;
               end
            end
            default:
            begin
               state <= fbp_pkg::ENG_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Completion pulse; an abort suppresses it even if the end arrives too
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         done <= 1'b0;
      end
      else
      begin
         done <= (state == fbp_pkg::ENG_RUN) && xfer_end && !abort && !logic_clear;
      end
   end

   assign active = (state == fbp_pkg::ENG_RUN);

endmodule : fbp_drive_engine

//--- hdl/fbp_top.sv
// FIFO byte ports of channel one and drive bus status/control, Wishbone slave
// How it works
// - With access mode set, reading a read-byte register pops the joined FIFO.
// - With access mode set, writing a write-byte register pushes the joined FIFO.
// - Each status bit reads 1 while its drive signal is asserted.
// - Status layout: request 7, ack 6, interrupt 5, ready 4, diag 1, active 0.
// - Active-low ack, diag and active pins read 1 at low level.
// - Status bits 3 and 2 read zero.
// - Writing 1 to control bit 6 returns the engine to idle.
// - Logic clear leaves every software register unchanged.
// - Control bit 3 picks direction: 0 drive to FIFO, 1 FIFO to drive.
// - Writing launch 1 starts a transfer; reads 1 while running; end sets done.
// - Writing launch 0 while running aborts without setting done.
`timescale 1ns/1ns
module fbp_top
(
   input wire logic clk,
   input wire logic rst,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // FIFO joined to channel one, read side
   input wire logic fifo_rd_valid,
   output logic fifo_rd_ready,
   input wire logic [7:0] fifo_rd_data,
   // FIFO joined to channel one, write side
   output logic fifo_wr_valid,
   input wire logic fifo_wr_ready,
   output logic [7:0] fifo_wr_data,
   // Drive bus
   input wire fbp_pkg::fbp_drive_pins_s drive_pins,
   input wire logic drive_xfer_end,
   output logic drive_xfer_active,
   output logic drive_dir,
   output logic drive_logic_clear,
   output logic chan_one_dir,
   output logic irq
);

   logic [7:0] wb_index;
   logic req;
   logic lane0;
   logic sel_read_byte;
   logic sel_write_byte;
   logic sel_status;
   logic sel_control;
   logic sel_chan_ctl;
   logic sel_irq_status;
   logic sel_irq_mask;
   logic access_mode;
   logic can_answer;
   logic take;
   logic wr_take;
   logic [7:0] chan_one_control;
   logic [7:0] drive_control;
   logic [7:0] pin_status;
   logic [fbp_pkg::IRQ_BITS-1:0] irq_status;
   logic [fbp_pkg::IRQ_BITS-1:0] irq_mask;
   logic [fbp_pkg::IRQ_BITS-1:0] irq_events;
   logic launch;
   logic abort;
   logic done;
   logic eng_active;
   logic drive_int_prev;
   logic [7:0] next_read_byte;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode
   assign wb_index = wb_adr_i[9:2];
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign lane0 = wb_sel_i[0];
   assign access_mode = chan_one_control[fbp_pkg::C1_ACCESS_MODE];

   always_comb
   begin
      sel_read_byte = 1'b0;
      sel_write_byte = 1'b0;
      sel_status = 1'b0;
      sel_control = 1'b0;
      sel_chan_ctl = 1'b0;
      sel_irq_status = 1'b0;
      sel_irq_mask = 1'b0;
      if (wb_adr_i[11:10] != 2'h0)
      begin
         sel_read_byte = 1'b0;
      end
      else if (wb_index == fbp_pkg::IDX_READ_BYTE_LO || wb_index == fbp_pkg::IDX_READ_BYTE_HI)
      begin
         sel_read_byte = 1'b1;
      end
      else if (wb_index == fbp_pkg::IDX_WRITE_BYTE_LO ||
               wb_index == fbp_pkg::IDX_WRITE_BYTE_HI)
      begin
         sel_write_byte = 1'b1;
      end
      else if (wb_index == fbp_pkg::IDX_PIN_STATUS)
      begin
         sel_status = 1'b1;
      end
      else if (wb_index == fbp_pkg::IDX_DRIVE_CONTROL)
      begin
         sel_control = 1'b1;
      end
      else if (wb_index == fbp_pkg::IDX_CHAN_ONE_CONTROL)
      begin
         sel_chan_ctl = 1'b1;
      end
      else if (wb_index == fbp_pkg::IDX_IRQ_STATUS)
      begin
         sel_irq_status = 1'b1;
      end
      else if (wb_index == fbp_pkg::IDX_IRQ_MASK)
      begin
         sel_irq_mask = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Byte ports; a FIFO access stalls the bus until the FIFO can move a byte
   always_comb
   begin
      can_answer = 1'b1;
      if (sel_read_byte && !wb_we_i && access_mode)
      begin
         can_answer = fifo_rd_valid;
      end
      else if (sel_write_byte && wb_we_i && lane0 && access_mode)
      begin
         can_answer = fifo_wr_ready;
      end
   end

   assign take = req && can_answer;
   assign wr_take = take && wb_we_i;

   // Pop only on the answering cycle, so one bus read moves exactly one byte
   assign fifo_rd_ready = take && sel_read_byte && !wb_we_i && access_mode;
   assign fifo_wr_valid = req && sel_write_byte && wb_we_i && lane0 && access_mode;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         fifo_wr_data <= 8'h00;
      end
      else if (req && sel_write_byte && wb_we_i && lane0)
      begin
         fifo_wr_data <= wb_dat_i[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Live pin view with active-low pins inverted inside
   always_comb
   begin
      pin_status = 8'h00;
      pin_status[fbp_pkg::ST_REQUEST] = drive_pins.drive_request_pin;
      pin_status[fbp_pkg::ST_ACK] = !drive_pins.drive_ack_pin_n;
      pin_status[fbp_pkg::ST_INTERRUPT] = drive_pins.drive_interrupt_pin;
      pin_status[fbp_pkg::ST_READY] = drive_pins.drive_ready_pin;
      pin_status[fbp_pkg::ST_DIAG] = !drive_pins.drive_diag_pin_n;
      pin_status[fbp_pkg::ST_ACTIVE] = !drive_pins.drive_active_pin_n;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software registers; logic clear never touches them
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         chan_one_control <= fbp_pkg::RST_CHAN_ONE_CONTROL;
      end
      else if (wr_take && sel_chan_ctl && lane0)
      begin
         chan_one_control <= {6'h00, wb_dat_i[fbp_pkg::C1_DIR], wb_dat_i[fbp_pkg::C1_ACCESS_MODE]};
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         drive_control <= fbp_pkg::RST_DRIVE_CONTROL;
      end
      else if (wr_take && sel_control && lane0)
      begin
         drive_control[fbp_pkg::CT_DIR] <= wb_dat_i[fbp_pkg::CT_DIR];
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         irq_mask <= fbp_pkg::RST_IRQ;
      end
      else if (wr_take && sel_irq_mask && lane0)
      begin
         irq_mask <= wb_dat_i[fbp_pkg::IRQ_BITS-1:0];
      end
   end

   assign chan_one_dir = chan_one_control[fbp_pkg::C1_DIR];
   assign drive_dir = drive_control[fbp_pkg::CT_DIR];

   ////////////////////////////////////////////////////////////////////////////
   // Launch, abort and clear strobes
   assign launch = wr_take && sel_control && lane0 && wb_dat_i[fbp_pkg::CT_LAUNCH];
   assign abort = wr_take && sel_control && lane0 && !wb_dat_i[fbp_pkg::CT_LAUNCH]
                  && eng_active;

   // Self-clearing: one-cycle pulse, nothing stored
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         drive_logic_clear <= 1'b0;
      end
      else
      begin
         drive_logic_clear <= wr_take && sel_control && lane0 && wb_dat_i[fbp_pkg::CT_CLEAR];
      end
   end

   fbp_drive_engine u_engine
   (
      .clk(clk),
      .rst(rst),
      .logic_clear(drive_logic_clear),
      .launch(launch),
      .abort(abort),
      .xfer_end(drive_xfer_end),
      .active(eng_active),
      .done(done)
   );

   assign drive_xfer_active = eng_active;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts: sticky, write one to clear, a new event wins over the clear
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         drive_int_prev <= 1'b0;
      end
      else
      begin
         drive_int_prev <= drive_pins.drive_interrupt_pin;
      end
   end

   always_comb
   begin
      irq_events = '0;
      irq_events[fbp_pkg::IRQ_DONE] = done;
      irq_events[fbp_pkg::IRQ_DRIVE_INT] = drive_pins.drive_interrupt_pin && !drive_int_prev;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         irq_status <= fbp_pkg::RST_IRQ;
      end
      else if (wr_take && sel_irq_status && lane0)
      begin
         irq_status <= (irq_status & ~wb_dat_i[fbp_pkg::IRQ_BITS-1:0]) | irq_events;
      end
      else
      begin
         irq_status <= irq_status | irq_events;
      end
   end

   assign irq = |(irq_status & irq_mask);

   ////////////////////////////////////////////////////////////////////////////
   // Read data and acknowledge
   always_comb
   begin
      next_read_byte = 8'h00;
      if (sel_read_byte)
      begin
         if (access_mode)
         begin
            next_read_byte = fifo_rd_data;
         end
         else
         begin
            next_read_byte = 8'h00;
         end
      end
      else if (sel_status)
      begin
         next_read_byte = pin_status;
      end
      else if (sel_control)
      begin
         // Clear and reserved bits read zero
         next_read_byte = {4'h0, drive_control[fbp_pkg::CT_DIR], 2'h0, eng_active};
      end
      else if (sel_chan_ctl)
      begin
         next_read_byte = chan_one_control;
      end
      else if (sel_irq_status)
      begin
         next_read_byte = {6'h00, irq_status};
      end
      else if (sel_irq_mask)
      begin
         next_read_byte = {6'h00, irq_mask};
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wb_ack_o <= 1'b0;
      end
      else
      begin
         wb_ack_o <= take;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wb_dat_o <= 32'h0000_0000;
      end
      else if (take && !wb_we_i)
      begin
         wb_dat_o <= {24'h000000, next_read_byte};
      end
   end

endmodule : fbp_top

//--- sim/fbp_top_asserts.sv
// Concurrent checks of the FIFO byte port and drive control block
`timescale 1ns/1ns
module fbp_top_asserts
(
   input wire logic clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic fifo_rd_valid,
   input wire logic fifo_rd_ready,
   input wire logic fifo_wr_valid,
   input wire fbp_pkg::fbp_drive_pins_s drive_pins,
   input wire logic drive_xfer_end,
   input wire logic drive_xfer_active,
   input wire logic drive_dir,
   input wire logic drive_logic_clear,
   input wire logic chan_one_dir
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   logic [7:0] stat;
   // Pins must be steady a while so sampling delay cannot matter
   assign stat = {drive_pins.drive_request_pin, ~drive_pins.drive_ack_pin_n,
      drive_pins.drive_interrupt_pin, drive_pins.drive_ready_pin, 2'b00,
      ~drive_pins.drive_diag_pin_n, ~drive_pins.drive_active_pin_n};
   sequence s_stat_rd;
      wb_ack_o && !wb_we_i && wb_adr_i == 12'h240 && drive_pins == $past(drive_pins, 3);
   endsequence
   sequence s_ctl_rd;
      wb_ack_o && !wb_we_i && wb_adr_i == 12'h244;
   endsequence
   sequence s_ctl_wr;
      wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 12'h244;
   endsequence
   a_status_map: assert property (s_stat_rd |-> {wb_dat_o[7], wb_dat_o[5:4]} ==
      {stat[7], stat[5:4]}) else $error("status map wrong");
   a_status_inv: assert property (s_stat_rd |-> {wb_dat_o[6], wb_dat_o[1:0]} ==
      {stat[6], stat[1:0]}) else $error("status polarity wrong");
   a_status_resvd: assert property (s_stat_rd |-> wb_dat_o[3:2] == 2'h0)
      else $error("status reserved set");
   a_ctrl_resvd: assert property (s_ctl_rd |-> {wb_dat_o[7:4], wb_dat_o[2:1]} == 6'h00)
      else $error("control reserved set");
   a_ctrl_dir: assert property (s_ctl_wr |=> drive_dir == $past(wb_dat_i[3]))
      else $error("direction not taken");
   a_clear_pulse: assert property (s_ctl_wr ##0 wb_dat_i[6] |-> ##[0:1] drive_logic_clear)
      else $error("no clear pulse");
   a_clear_keep: assert property (drive_logic_clear |=> $stable(drive_dir) &&
      $stable(chan_one_dir)) else $error("clear changed registers");
   a_clear_idle: assert property (drive_logic_clear |=> !drive_xfer_active)
      else $error("clear left engine running");
   a_launch_run: assert property (s_ctl_wr ##0 (wb_dat_i[0] && !wb_dat_i[6]) |->
      ##[0:1] drive_xfer_active) else $error("launch did not start");
   a_end_stop: assert property (drive_xfer_active && drive_xfer_end |=>
      !drive_xfer_active) else $error("end did not stop");
   a_abort_stop: assert property (s_ctl_wr ##0 !wb_dat_i[0] |=> !drive_xfer_active)
      else $error("abort did not stop");
   a_pop_when: assert property (fifo_rd_ready |-> fifo_rd_valid && wb_cyc_i &&
      !wb_we_i) else $error("stray pop");
   a_push_when: assert property (fifo_wr_valid |-> wb_cyc_i && wb_we_i &&
      wb_sel_i[0]) else $error("stray push");
endmodule : fbp_top_asserts
bind fbp_top fbp_top_asserts u_chk (.clk, .rst, .wb_cyc_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
   .wb_dat_i, .wb_dat_o, .wb_ack_o, .fifo_rd_valid, .fifo_rd_ready, .fifo_wr_valid,
   .drive_pins, .drive_xfer_end, .drive_xfer_active, .drive_dir, .drive_logic_clear,
   .chan_one_dir);

//--- sim/fbp_drive_model.sv
// Behavioural drive on the far side of the drive bus
`timescale 1ns/1ns
module fbp_drive_model
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [5:0] assert_set,
   input wire logic end_req,
   output fbp_pkg::fbp_drive_pins_s drive_pins,
   output logic drive_xfer_end
);
   // Active-low pins go low when asserted
   assign drive_pins = assert_set ^ 6'h13;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         drive_xfer_end <= 1'b0;
      else
         drive_xfer_end <= end_req & ~drive_xfer_end;
   end
endmodule : fbp_drive_model

//--- sim/testbench.sv
// Self-checking bench of the FIFO byte port and drive control block
`timescale 1ns/1ns
module testbench;
   logic clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, end_req = 0;
   logic fifo_rd_valid = 0, fifo_wr_ready = 0;
   logic [11:0] wb_adr_i = 12'h000;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, rnd = 32'h5A11, wb_dat_o;
   logic [7:0] fifo_rd_data = 8'h00, fifo_wr_data, q, e;
   logic [5:0] assert_set = 6'h00;
   logic wb_ack_o, fifo_rd_ready, fifo_wr_valid, drive_xfer_end, drive_xfer_active;
   logic drive_dir, drive_logic_clear, chan_one_dir, irq;
   fbp_pkg::fbp_drive_pins_s drive_pins;
   int fails = 0, cmp_count = 0;
   logic [7:0] src_q[$], got_q[$], wexp_q[$];
   fbp_top uut (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .fifo_rd_valid, .fifo_rd_ready, .fifo_rd_data, .fifo_wr_valid,
      .fifo_wr_ready, .fifo_wr_data, .drive_pins, .drive_xfer_end, .drive_xfer_active,
      .drive_dir, .drive_logic_clear, .chan_one_dir, .irq);
   fbp_drive_model drv (.clk, .rst, .assert_set, .end_req, .drive_pins, .drive_xfer_end);
   always #20 clk = ~clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   ////////////////////////////////////////
   // Joined FIFO: stalls at random, shows a moving pattern when empty
   always @(posedge clk)
   begin
      rnd <= lfsr(rnd);
      if (fifo_rd_valid && fifo_rd_ready)
         void'(src_q.pop_front());
      fifo_rd_valid <= src_q.size() > 0 && rnd[0];
      fifo_rd_data <= src_q.size() > 0 ? src_q[0] : rnd[15:8];
      if (fifo_wr_valid && fifo_wr_ready)
         got_q.push_back(fifo_wr_data);
      // Ready never in the first request cycle: write data lands one edge late
      fifo_wr_ready <= fifo_wr_valid && !fifo_wr_ready && rnd[1];
   end
   task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n = 0;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= {24'h0, d};
      @(posedge clk);
      while (wb_ack_o !== 1'b1 && n < 300)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 300)
         fails++;
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : wb
   task automatic chk_byte(input logic [7:0] g, input logic [7:0] x);
      cmp_count++;
      if (g !== x)
      begin
         fails++;
         $display("unexpected at %0t: byte %h, want %h", $time, g, x);
      end
   endtask : chk_byte
   task automatic chk_bit(input logic g, input logic x);
      cmp_count++;
      if (g !== x)
      begin
         fails++;
         $display("unexpected at %0t: bit %b, want %b", $time, g, x);
      end
   endtask : chk_bit
   task automatic rd(input logic [11:0] a, input logic [7:0] x);
      wb(1'b0, a, 8'h00);
      chk_byte(q, x);
   endtask : rd
   task automatic pulse_end;
      @(posedge clk);
      end_req <= 1'b1;
      @(posedge clk);
      end_req <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : pulse_end
   task finish_test;
      $display("mismatches %0d, comparisons %0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   initial
   begin
      #2000000;
      fails++;
      finish_test;
   end
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd(12'h244, 8'h00);
      rd(12'h200, 8'h00);
      src_q.push_back(8'hA5);
      rd(12'h230, 8'h00);
      rd(12'h234, 8'h00);
      wb(1'b1, 12'h238, 8'h3C);
      chk_bit(src_q.size() == 1, 1'b1);
      wb(1'b1, 12'h200, 8'h01);
      chk_bit(chan_one_dir, 1'b0);
      rd(12'h230, 8'hA5);
      for (int i = 0; i < 6; i++)
      begin
         e = rnd[7:0];
         src_q.push_back(e);
         rd(i[0] ? 12'h234 : 12'h230, e);
      end
      wb(1'b1, 12'h200, 8'h03);
      chk_bit(chan_one_dir, 1'b1);
      for (int i = 0; i < 6; i++)
      begin
         e = rnd[15:8];
         wexp_q.push_back(e);
         wb(1'b1, i[0] ? 12'h23C : 12'h238, e);
      end
      chk_bit(got_q.size() == 6, 1'b1);
      foreach (got_q[i]) chk_byte(got_q[i], wexp_q[i]);
      for (int i = 0; i < 10; i++)
      begin
         @(posedge clk);
         e[5:0] = i == 8 ? 6'h3F : (i == 9 ? 6'h00 : rnd[5:0]);
         assert_set <= e[5:0];
         repeat (4) @(posedge clk);
         rd(12'h240, {e[5:2], 2'b00, e[1:0]});
      end
      wb(1'b1, 12'h260, 8'h03);
      rd(12'h260, 8'h00);
      wb(1'b1, 12'h264, 8'h01);
      wb(1'b1, 12'h244, 8'h08);
      chk_bit(drive_dir, 1'b1);
      wb(1'b1, 12'h244, 8'h09);
      rd(12'h244, 8'h09);
      chk_bit(drive_xfer_active, 1'b1);
      pulse_end;
      chk_bit(drive_xfer_active, 1'b0);
      rd(12'h244, 8'h08);
      rd(12'h260, 8'h01);
      chk_bit(irq, 1'b1);
      wb(1'b1, 12'h260, 8'h01);
      @(posedge clk);
      chk_bit(irq, 1'b0);
      wb(1'b1, 12'h244, 8'h01);
      rd(12'h244, 8'h01);
      chk_bit(drive_dir, 1'b0);
      wb(1'b1, 12'h244, 8'h00);
      chk_bit(drive_xfer_active, 1'b0);
      // A late end after an abort must not count as completion
      pulse_end;
      rd(12'h260, 8'h00);
      wb(1'b1, 12'h264, 8'h02);
      assert_set <= 6'h08;
      repeat (4) @(posedge clk);
      rd(12'h260, 8'h02);
      chk_bit(irq, 1'b1);
      wb(1'b1, 12'h260, 8'h02);
      // Clear only while idle, as software must
      wb(1'b1, 12'h244, 8'h48);
      rd(12'h244, 8'h08);
      rd(12'h264, 8'h02);
      // Lane zero disabled: write acked but dropped
      wb_sel_i <= 4'hE;
      wb(1'b1, 12'h264, 8'h01);
      wb_sel_i <= 4'hF;
      rd(12'h264, 8'h02);
      rd(12'h200, 8'h03);
      chk_bit(irq, 1'b0);
      wb(1'b1, 12'h244, 8'h09);
      rd(12'h244, 8'h09);
      wb(1'b1, 12'h240, 8'hFF);
      rd(12'h240, 8'h20);
      wb(1'b1, 12'hC00, 8'hFF);
      rd(12'hC00, 8'h00);
      finish_test;
   end
endmodule : testbench
